// [core/tazi_core.sv]
// Alarm qualification, zone interlock restraint, override thresholds and module check.
// Assumes a classic Wishbone master and element pickups on the same clock.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "tazi_consts.svh"
module tazi_core #(
    parameter int TICK_CYCLES = `TAZI_TICK_NS / `TAZI_CLK_NS
) (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST,
    // Wishbone slave
    input  wire logic                 WB_CYC_I,
    input  wire logic                 WB_STB_I,
    input  wire logic                 WB_WE_I,
    input  wire logic [7:0]           WB_ADR_I,
    input  wire logic [3:0]           WB_SEL_I,
    input  wire logic [31:0]          WB_DAT_I,
    output logic      [31:0]          WB_DAT_O,
    output logic                      WB_ACK_O,
    // Measurement front end and elements
    input  wire logic                 HALF_CYCLE_TICK,
    input  wire logic [15:0]          PHASE_CUR_MAX,
    input  wire logic [15:0]          FAULT_CUR,
    input  wire logic                 GF_ALARM_PICKUP,
    input  wire logic                 GF_PICKUP,
    input  wire logic                 ST_PICKUP,
    input  wire logic                 INST_PICKUP,
    // Pins
    input  wire logic                 ZONE_INTERLOCK_IN,
    input  wire logic                 BREAKER_CLOSED,
    input  wire logic                 BATTERY_POWER,
    // Breaker info module and memory
    input  wire logic                 BIM_VALID,
    input  wire tazi_pkg::tazi_bim_t  BIM_DATA,
    input  wire logic                 NV_MARRIED,
    input  wire tazi_pkg::tazi_bim_t  NV_DATA,
    output logic                      NV_WRITE,
    output tazi_pkg::tazi_bim_t       NV_WDATA,
    // Indications and protection controls
    output logic                      GF_ALARM_OUT,
    output logic [1:0]                CUR_ALARM_OUT,
    output logic                      RESTRAIN_GF,
    output logic                      RESTRAIN_ST,
    output logic                      RESTRAIN_INST,
    output logic                      INST_BLOCK,
    output logic                      INST_TRIP,
    output logic                      ZONE_INTERLOCK_OUT,
    output logic [15:0]               PICKUP_EFF,
    output logic [15:0]               OVERRIDE_THRESH,
    output logic                      OVERRIDE_EN,
    output logic                      MCR_ACTIVE,
    output logic                      BIM_ERROR
);
    import tazi_pkg::*;

    function automatic logic [15:0] sp_permil(input logic [3:0] code);
        sp_permil = 16'(`TAZI_SP_BASE + `TAZI_SP_STEP * {12'h000, code});
    endfunction : sp_permil

    function automatic logic [15:0] scale_pct(input logic [15:0] v, input logic [7:0] pct);
        scale_pct = 16'((32'(v) * 32'(pct)) / `TAZI_PCT_HUNDRED);
    endfunction : scale_pct

    tazi_ctrl_t      ctrl_r;
    tazi_sp_t        sp_r [2];
    logic [15:0]     withstand_r;
    logic [15:0]     short_circ_r;
    logic [15:0]     pickup_r;
    logic [15:0]     mcr_thresh_r;
    logic            cfg_reject_r;
    logic            wb_req;
    logic [31:0]     wmask;
    logic [31:0]     wdat;
    logic [31:0]     rdat;
    logic [2:0]      pin_raw;
    logic [2:0]      pin_s1_r;
    logic [2:0]      pin_s2_r;
    logic [2:0]      pin_s3_r;
    logic [2:0]      pin_r;
    logic            zi_in;
    logic            closed_in;
    logic            batt_in;
    logic            zi_prev_r;
    logic            closed_prev_r;
    logic [15:0]     tick_cnt_r;
    logic            ms_tick_r;
    logic [15:0]     alm_cnt_r [2];
    logic [1:0]      alm_act_r;
    logic            restrained_r;
    logic [15:0]     hold_cnt_r;
    logic            pick_prev_r;
    logic            part_pick;
    logic            thr_ok;
    logic            inst_part;
    logic [7:0]      ihc_cnt_r;
    logic            ihold_r;
    logic [7:0]      ihold_hc;
    logic [7:0]      itrip_hc;
    logic [7:0]      mcr_cnt_r;
    logic            mcr_act_r;
    tazi_bim_st_t    bim_st_r;
    logic [2:0]      settle_r;

    assign wb_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign pin_raw  = {BATTERY_POWER, BREAKER_CLOSED, ZONE_INTERLOCK_IN};
    assign zi_in    = pin_r[0];
    assign closed_in = pin_r[1];
    assign batt_in  = pin_r[2];
    // Threshold mode only exists with the instantaneous option
    assign thr_ok   = ctrl_r.thr_en && ctrl_r.inst_opt;
    assign inst_part = ctrl_r.part_inst && ctrl_r.inst_opt;
    assign part_pick = (ctrl_r.part_gf && GF_PICKUP) || (ctrl_r.part_st && ST_PICKUP)
                     || (inst_part && INST_PICKUP);
    assign ihold_hc = ctrl_r.variant ? `TAZI_IHOLD_HC_B : `TAZI_IHOLD_HC_A;
    assign itrip_hc = ctrl_r.variant ? `TAZI_ITRIP_HC_B : `TAZI_ITRIP_HC_A;

    always_comb
    begin
        wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
        wdat  = 32'h0000_0000;
        case (WB_ADR_I)
            `TAZI_ADR_CTRL: wdat = {16'h0000, ctrl_r};
            `TAZI_ADR_ALM0: wdat = {24'h00_0000, sp_r[0]};
            `TAZI_ADR_ALM1: wdat = {24'h00_0000, sp_r[1]};
            `TAZI_ADR_RATE: wdat = {short_circ_r, withstand_r};
            `TAZI_ADR_PICK: wdat = {mcr_thresh_r, pickup_r};
            default:        wdat = 32'h0000_0000;
        endcase
        wdat = (wdat & ~wmask) | (WB_DAT_I & wmask);
    end

    always_comb
    begin
        case (WB_ADR_I)
            `TAZI_ADR_CTRL: rdat = {16'h0000, ctrl_r};
            `TAZI_ADR_ALM0: rdat = {24'h00_0000, sp_r[0]};
            `TAZI_ADR_ALM1: rdat = {24'h00_0000, sp_r[1]};
            `TAZI_ADR_STAT: rdat = {24'h00_0000, cfg_reject_r, BIM_ERROR, mcr_act_r, restrained_r,
                                    ZONE_INTERLOCK_OUT, GF_ALARM_PICKUP, alm_act_r};
            `TAZI_ADR_RATE: rdat = {short_circ_r, withstand_r};
            `TAZI_ADR_PICK: rdat = {mcr_thresh_r, pickup_r};
            default:        rdat = 32'h0000_0000;
        endcase
    end

    // Bus answer: ack one cycle after the request, write takes effect on that edge
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else
        begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= (wb_req && !WB_WE_I) ? rdat : 32'h0000_0000;
        end
    end

    // Restrained bands live in the element logic; only the pickup is shifted here
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_r       <= tazi_ctrl_t'(`TAZI_CTRL_RST);
            sp_r[0]      <= tazi_sp_t'(`TAZI_SP_RST);
            sp_r[1]      <= tazi_sp_t'(`TAZI_SP_RST);
            withstand_r  <= 16'h0000;
            short_circ_r <= 16'h0000;
            pickup_r     <= 16'h0000;
            mcr_thresh_r <= 16'h0000;
            cfg_reject_r <= 1'b0;
        end
        else if (wb_req && WB_WE_I)
        begin
            case (WB_ADR_I)
                `TAZI_ADR_CTRL: ctrl_r <= tazi_ctrl_t'({5'h00, wdat[10:0]});
                `TAZI_ADR_ALM0, `TAZI_ADR_ALM1:
                begin
                    // Out of range codes or OFF above ON leave the old setting
                    if (wdat[3:0] > `TAZI_SP_MAX_CODE || wdat[7:4] > wdat[3:0])
                        cfg_reject_r <= 1'b1;
                    else
                    begin
                        cfg_reject_r <= 1'b0;
                        sp_r[WB_ADR_I[3]] <= tazi_sp_t'(wdat[7:0]);
                    end
                end
                `TAZI_ADR_RATE:
                begin
                    withstand_r  <= wdat[15:0];
                    short_circ_r <= wdat[31:16];
                end
                `TAZI_ADR_PICK:
                begin
                    pickup_r     <= wdat[15:0];
                    mcr_thresh_r <= wdat[31:16];
                end
                default: ;
            endcase
        end
    end

    // Pin synchronisers; a level counts once stages two and three agree
    generate
        for (genvar p = 0; p < 3; p++)
        begin : g_pin
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    pin_s1_r[p] <= 1'b0;
                    pin_s2_r[p] <= 1'b0;
                    pin_s3_r[p] <= 1'b0;
                    pin_r[p]    <= 1'b0;
                end
                else
                begin
                    pin_s1_r[p] <= pin_raw[p];
                    pin_s2_r[p] <= pin_s1_r[p];
                    pin_s3_r[p] <= pin_s2_r[p];
                    if (pin_s2_r[p] == pin_s3_r[p])
                        pin_r[p] <= pin_s3_r[p];
                end
            end
        end
    endgenerate

    // Millisecond tick from the system clock
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            tick_cnt_r <= 16'h0000;
            ms_tick_r  <= 1'b0;
        end
        else
        begin
            ms_tick_r  <= (tick_cnt_r == 16'(TICK_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == 16'(TICK_CYCLES - 1)) ? 16'h0000 : 16'(tick_cnt_r + 16'h0001);
        end
    end

    // Current alarms: indication only, nothing here reaches a trip
    generate
        for (genvar a = 0; a < 2; a++)
        begin : g_alm
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    alm_cnt_r[a] <= 16'h0000;
                    alm_act_r[a] <= 1'b0;
                end
                else if (alm_cnt_r[a] > `TAZI_ALARM_MS)
                begin
                    alm_act_r[a] <= !alm_act_r[a];
                    alm_cnt_r[a] <= 16'h0000;
                end
                else if (!alm_act_r[a] ? (PHASE_CUR_MAX > sp_permil(sp_r[a].on_code))
                                       : (PHASE_CUR_MAX < sp_permil(sp_r[a].off_code)))
                begin
                    if (ms_tick_r)
                        alm_cnt_r[a] <= 16'(alm_cnt_r[a] + 16'h0001);
                end
                else
                    alm_cnt_r[a] <= 16'h0000;
            end
        end
    endgenerate

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            GF_ALARM_OUT  <= 1'b0;
            CUR_ALARM_OUT <= 2'b00;
        end
        else
        begin
            GF_ALARM_OUT  <= GF_ALARM_PICKUP && ctrl_r.gf_out_map;
            CUR_ALARM_OUT <= alm_act_r & ctrl_r.alm_out_map;
        end
    end

    // Restraint decided at pickup entry, held 50 ms after the input drops
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            restrained_r <= 1'b0;
            hold_cnt_r   <= 16'h0000;
            pick_prev_r  <= 1'b0;
        end
        else
        begin
            pick_prev_r <= part_pick;
            if (!restrained_r)
            begin
                hold_cnt_r <= 16'h0000;
                if (part_pick && !pick_prev_r && zi_in)
                    restrained_r <= 1'b1;
            end
            else if (zi_in)
                hold_cnt_r <= 16'h0000;
            else if (hold_cnt_r >= `TAZI_HOLD_MS)
                restrained_r <= 1'b0;
            else if (ms_tick_r)
                hold_cnt_r <= 16'(hold_cnt_r + 16'h0001);
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RESTRAIN_GF        <= 1'b0;
            RESTRAIN_ST        <= 1'b0;
            RESTRAIN_INST      <= 1'b0;
            ZONE_INTERLOCK_OUT <= 1'b0;
            PICKUP_EFF         <= 16'h0000;
        end
        else
        begin
            RESTRAIN_GF   <= restrained_r && ctrl_r.part_gf;
            RESTRAIN_ST   <= restrained_r && ctrl_r.part_st;
            RESTRAIN_INST <= restrained_r && inst_part;
            if (thr_ok)
                ZONE_INTERLOCK_OUT <= FAULT_CUR > scale_pct(pickup_r, `TAZI_PCT_OUT);
            else
                ZONE_INTERLOCK_OUT <= GF_PICKUP || ST_PICKUP || INST_PICKUP;
            // Shift applies to short time and instantaneous, never ground fault
            PICKUP_EFF <= (thr_ok && restrained_r) ? scale_pct(pickup_r, `TAZI_PCT_SHIFT) : pickup_r;
        end
    end

    // Instantaneous hold-off counted in half cycles from the input's arrival
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            zi_prev_r  <= 1'b0;
            ihold_r    <= 1'b0;
            ihc_cnt_r  <= 8'h00;
            INST_BLOCK <= 1'b0;
            INST_TRIP  <= 1'b0;
        end
        else
        begin
            zi_prev_r <= zi_in;
            INST_TRIP <= 1'b0;
            if (zi_in && !zi_prev_r && inst_part)
            begin
                ihold_r   <= 1'b1;
                ihc_cnt_r <= 8'h00;
            end
            else if (ihold_r && HALF_CYCLE_TICK)
            begin
                ihc_cnt_r <= 8'(ihc_cnt_r + 8'h01);
                if (8'(ihc_cnt_r + 8'h01) == itrip_hc)
                begin
                    ihold_r   <= 1'b0;
                    INST_TRIP <= INST_PICKUP;
                end
            end
            INST_BLOCK <= ihold_r && (ihc_cnt_r < ihold_hc);
        end
    end

    // Making-current window from closing for six cycles
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            closed_prev_r <= 1'b0;
            mcr_act_r     <= 1'b0;
            mcr_cnt_r     <= 8'h00;
        end
        else
        begin
            closed_prev_r <= closed_in;
            if (closed_in && !closed_prev_r)
            begin
                mcr_act_r <= 1'b1;
                mcr_cnt_r <= 8'h00;
            end
            else if (mcr_act_r && HALF_CYCLE_TICK)
            begin
                mcr_cnt_r <= 8'(mcr_cnt_r + 8'h01);
                if (mcr_cnt_r == 8'(`TAZI_MCR_HC - 8'h01))
                    mcr_act_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            MCR_ACTIVE      <= 1'b0;
            OVERRIDE_EN     <= 1'b0;
            OVERRIDE_THRESH <= 16'h0000;
        end
        else
        begin
            MCR_ACTIVE <= mcr_act_r;
            if (mcr_act_r)
            begin
                OVERRIDE_EN     <= 1'b1;
                OVERRIDE_THRESH <= mcr_thresh_r;
            end
            else
            begin
                OVERRIDE_EN     <= withstand_r != short_circ_r;
                OVERRIDE_THRESH <= scale_pct(withstand_r, (ctrl_r.std_second && ctrl_r.adj_inst_off)
                                             ? `TAZI_PCT_HSO_ALT : `TAZI_PCT_HSO);
            end
        end
    end

    // Filtered pins read low until the filter fills; a battery start must not look external
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            settle_r <= 3'h0;
        else if (settle_r != `TAZI_PIN_SETTLE)
            settle_r <= 3'(settle_r + 3'h1);
    end

    // Module check: one look per power-up, none on battery
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            bim_st_r  <= TAZI_BIM_WAIT;
            BIM_ERROR <= 1'b0;
            NV_WRITE  <= 1'b0;
            NV_WDATA  <= '0;
        end
        else
        begin
            NV_WRITE <= 1'b0;
            case (bim_st_r)
                TAZI_BIM_WAIT:
                begin
                    if (BIM_VALID && !batt_in && settle_r == `TAZI_PIN_SETTLE)
                    begin
                        bim_st_r <= TAZI_BIM_DONE;
                        if (!NV_MARRIED)
                        begin
                            NV_WRITE <= 1'b1;
                            NV_WDATA <= BIM_DATA;
                        end
                        else
                            BIM_ERROR <= BIM_DATA != NV_DATA;
                    end
                end
                TAZI_BIM_DONE: bim_st_r <= TAZI_BIM_DONE;
                default:       bim_st_r <= TAZI_BIM_WAIT;
            endcase
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_alarm_on_qual: assert property ($rose(alm_act_r[0]) |-> $past(alm_cnt_r[0]) > `TAZI_ALARM_MS)
        else $error("current alarm raised before qualification time");
    a_alarm_off_qual: assert property ($fell(alm_act_r[1]) |-> $past(alm_cnt_r[1]) > `TAZI_ALARM_MS)
        else $error("current alarm cleared before qualification time");
    a_alarm_follow: assert property (CUR_ALARM_OUT[0] |-> $past(alm_act_r[0] && ctrl_r.alm_out_map[0]))
        else $error("alarm output does not follow alarm state");
    a_setpoint_order: assert property (sp_r[0].off_code <= sp_r[0].on_code && sp_r[1].off_code <= sp_r[1].on_code)
        else $error("stored OFF setpoint above ON setpoint");
    a_restrain_hold: assert property ($fell(restrained_r) |-> $past(!zi_in && hold_cnt_r >= `TAZI_HOLD_MS))
        else $error("restraint released early");
    a_restrain_part: assert property (RESTRAIN_GF |-> $past(restrained_r && ctrl_r.part_gf))
        else $error("non participating element restrained");
    a_inst_trip_when: assert property (INST_TRIP |-> $past(ihc_cnt_r) == 8'(itrip_hc - 8'h01))
        else $error("restrained instantaneous trip at wrong half cycle");
    a_mcr_window: assert property ($fell(mcr_act_r) |-> $past(HALF_CYCLE_TICK && mcr_cnt_r == 8'h0b))
        else $error("making current window wrong length");
    a_override_none: assert property ((!mcr_act_r && withstand_r == short_circ_r) |=> !OVERRIDE_EN)
        else $error("override enabled with equal ratings");
    a_bim_battery: assert property ($rose(BIM_ERROR) |-> $past(!batt_in && NV_MARRIED && BIM_VALID))
        else $error("module error set without a valid check");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
endmodule : tazi_core

// [core/tazi_consts.svh]
// Constants of the trip alarm and zone interlock block.
// Assumes a 50 MHz system clock and a 1 ms qualification tick.
`ifndef TAZI_CONSTS_SVH
`define TAZI_CONSTS_SVH
`define TAZI_CLK_NS       20
`define TAZI_TICK_NS      1000000
`define TAZI_ALARM_MS     16'hea60
`define TAZI_HOLD_MS      16'h0032
`define TAZI_MCR_HC       8'h0c
`define TAZI_IHOLD_HC_A   8'h06
`define TAZI_ITRIP_HC_A   8'h07
`define TAZI_IHOLD_HC_B   8'h09
`define TAZI_ITRIP_HC_B   8'h09
`define TAZI_SP_BASE      16'h01f4
`define TAZI_SP_STEP      16'h0032
`define TAZI_SP_MAX_CODE  4'ha
`define TAZI_PCT_HUNDRED  32'h0000_0064
`define TAZI_PCT_HSO      8'h6b
`define TAZI_PCT_HSO_ALT  8'h62
`define TAZI_PCT_SHIFT    8'h7b
`define TAZI_PCT_OUT      8'h51
`define TAZI_ADR_CTRL     8'h00
`define TAZI_ADR_ALM0     8'h04
`define TAZI_ADR_ALM1     8'h08
`define TAZI_ADR_STAT     8'h0c
`define TAZI_ADR_RATE     8'h10
`define TAZI_ADR_PICK     8'h14
`define TAZI_CTRL_RST     16'h0000
`define TAZI_SP_RST       8'h00
`define TAZI_PIN_SETTLE   3'h4
`endif

// [core/tazi_pkg.sv]
// Types of the trip alarm and zone interlock block.
// Constants live in tazi_consts.svh.
package tazi_pkg;
    typedef struct packed {
        logic [4:0] pad;
        logic [1:0] alm_out_map;
        logic       gf_out_map;
        logic       adj_inst_off;
        logic       std_second;
        logic       thr_en;
        logic       inst_opt;
        logic       variant;
        logic       part_inst;
        logic       part_st;
        logic       part_gf;
    } tazi_ctrl_t;
    typedef struct packed {
        logic [3:0] off_code;
        logic [3:0] on_code;
    } tazi_sp_t;
    typedef struct packed {
        logic [7:0] sensor;
        logic [5:0] interruption;
        logic [1:0] poles;
    } tazi_bim_t;
    typedef enum logic [1:0] {TAZI_BIM_WAIT, TAZI_BIM_DONE} tazi_bim_st_t;
endpackage : tazi_pkg

// [sim/tazi_peer.sv]
// Downstream trip unit seen over the zone interlock line.
// Assumes the bench raises pickup when that unit sees a fault.
`timescale 1ns/1ps
module tazi_peer (
    // Clock
    input  wire logic clk,
    // Fault seen downstream
    input  wire logic pickup,
    // Interlock line toward the block
    output logic      zone_out
);
    // Line carries no cause, only a bare pickup level
    always_ff @(posedge clk)
        zone_out <= pickup;
endmodule : tazi_peer

// [sim/test_tazi_core.sv]
// Bench for the trip alarm and zone interlock block.
// Assumes TICK_CYCLES of 1 so a 60 s alarm spans about 60001 cycles.
`timescale 1ns/1ps
`include "tazi_consts.svh"
module test_tazi_core;
    import tazi_pkg::*;
    logic        CLK = 0, RST = 1, cyc = 0, we = 0, ht = 0, gap = 0, gfp = 0, stp = 0, dn = 0, zin, ack;
    logic        ip = 0, cl = 0, bat = 0, bv = 0, nm = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wd = 0, rd, dat;
    logic [15:0] cur = 0, fc = 0, ovt, pke;
    tazi_bim_t   bd = '0, nd = '0, nvd;
    logic [1:0]  alm;
    logic        gfo, rgf, rst_, rin, iblk, itr, zo, ove, mca, bme, nvw;
    int          bad_count = 0, tests_run = 0;
    initial forever #10 CLK = ~CLK;
    always @(posedge CLK)
        ht <= ~ht;
    tazi_peer u_tazi_peer (.clk(CLK), .pickup(dn), .zone_out(zin));
    tazi_core #(.TICK_CYCLES(1)) u_tazi_core (.CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(dat), .WB_ACK_O(ack),
        .HALF_CYCLE_TICK(ht), .PHASE_CUR_MAX(cur), .FAULT_CUR(fc), .GF_ALARM_PICKUP(gap),
        .GF_PICKUP(gfp), .ST_PICKUP(stp), .INST_PICKUP(ip), .ZONE_INTERLOCK_IN(zin), .BREAKER_CLOSED(cl),
        .BATTERY_POWER(bat), .BIM_VALID(bv), .BIM_DATA(bd), .NV_MARRIED(nm), .NV_DATA(nd),
        .NV_WRITE(nvw), .NV_WDATA(nvd), .GF_ALARM_OUT(gfo), .CUR_ALARM_OUT(alm), .RESTRAIN_GF(rgf),
        .RESTRAIN_ST(rst_), .RESTRAIN_INST(rin), .INST_BLOCK(iblk), .INST_TRIP(itr), .ZONE_INTERLOCK_OUT(zo),
        .PICKUP_EFF(pke), .OVERRIDE_THRESH(ovt), .OVERRIDE_EN(ove), .MCR_ACTIVE(mca), .BIM_ERROR(bme));
    task automatic print_verdict;
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Classic single cycle; read data taken at the ack edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge CLK);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge CLK);
            if (ack === 1'b1)
                break;
        end
        if (i == 20)
        begin
            bad_count++;
            print_verdict();
        end
        rd = dat;
        cyc <= 1'b0;
    endtask : bus
    // Interlock arrival with instantaneous participating; trip edge counted from the downstream pickup rising, one clock before the line
    task automatic inst_run(input int lo, input int hi);
        int i;
        dn <= 1'b1;
        repeat (10) @(posedge CLK);
        chk("inst_block", 1, iblk);
        for (i = 10; i < 40; i++)
        begin
            @(posedge CLK);
            if (itr === 1'b1)
                break;
        end
        chk("inst_trip_edge", 1, i >= lo && i <= hi);
        @(posedge CLK);
        chk("inst_unblock", 0, iblk);
        dn <= 1'b0;
        repeat (8) @(posedge CLK);
    endtask : inst_run
    initial
    begin
        repeat (90000) @(posedge CLK);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        bus(0, `TAZI_ADR_CTRL, 0);
        chk("ctrl_reset", 0, rd);
        bus(1, `TAZI_ADR_ALM0, 32'h21);
        bus(0, `TAZI_ADR_STAT, 0);
        chk("reject_flag", 1, rd[7]);
        bus(0, `TAZI_ADR_ALM0, 0);
        chk("alm0_kept", 0, rd);
        bus(1, `TAZI_ADR_CTRL, 32'h303);
        gap <= 1'b1;
        repeat (4) @(posedge CLK);
        chk("gf_out", 1, gfo);
        bus(0, `TAZI_ADR_STAT, 0);
        chk("gf_stat", 1, rd[2]);
        // Pickup arrives while the interlock line is already up
        dn <= 1'b1;
        repeat (6) @(posedge CLK);
        gfp <= 1'b1;
        repeat (4) @(posedge CLK);
        chk("restr_gf", 1, rgf);
        chk("restr_st", 1, rst_);
        chk("restr_inst", 0, rin);
        dn <= 1'b0;
        repeat (45) @(posedge CLK);
        chk("hold_50ms", 1, rgf);
        repeat (15) @(posedge CLK);
        chk("released", 0, rgf);
        stp <= 1'b1;
        repeat (6) @(posedge CLK);
        chk("unrestrained", 0, rst_);
        bus(1, `TAZI_ADR_ALM0, 0);
        cur <= 16'd600;
        repeat (59990) @(posedge CLK);
        chk("alarm_early", 0, alm[0]);
        repeat (30) @(posedge CLK);
        chk("alarm_on", 1, alm[0]);
        bus(0, `TAZI_ADR_STAT, 0);
        chk("stat_alarm", 32'h05, rd & 32'h85);
        bus(1, `TAZI_ADR_RATE, 32'h07d0_03e8);
        bus(1, `TAZI_ADR_PICK, 32'h0bb8_03e8);
        repeat (2) @(posedge CLK);
        chk("hso_on", 1, ove);
        chk("hso_107", 16'd1070, ovt);
        // Second type, selective instantaneous off, threshold mode, instantaneous participates
        bus(1, `TAZI_ADR_CTRL, 32'h3f7);
        repeat (2) @(posedge CLK);
        chk("hso_98", 16'd980, ovt);
        bus(1, `TAZI_ADR_RATE, 32'h03e8_03e8);
        repeat (2) @(posedge CLK);
        chk("hso_none", 0, ove);
        cl <= 1'b1;
        repeat (8) @(posedge CLK);
        chk("mcr_on", 1, mca);
        chk("mcr_thr", 16'd3000, ovt);
        repeat (12) @(posedge CLK);
        chk("mcr_mid", 1, mca);
        repeat (18) @(posedge CLK);
        chk("mcr_end", 0, mca);
        chk("hso_after", 16'd980, ovt);
        fc <= 16'd800;
        repeat (2) @(posedge CLK);
        chk("thr_below", 0, zo);
        fc <= 16'd820;
        repeat (2) @(posedge CLK);
        chk("thr_above", 1, zo);
        gfp <= 1'b0;
        stp <= 1'b0;
        ip  <= 1'b1;
        inst_run(18, 22);
        bus(1, `TAZI_ADR_CTRL, 32'h3ff);
        inst_run(22, 26);
        ip <= 1'b0;
        dn <= 1'b1;
        repeat (8) @(posedge CLK);
        stp <= 1'b1;
        repeat (4) @(posedge CLK);
        chk("pick_shift", 16'd1230, pke);
        chk("restr_inst_on", 1, rin);
        bd <= 16'h1234;
        bv <= 1'b1;
        repeat (2) @(posedge CLK);
        chk("nv_write", 1, nvw);
        chk("nv_wdata", 16'h1234, nvd);
        chk("bim_first", 0, bme);
        // Later power-up, first on battery, then on external supply
        bat <= 1'b1;
        nm  <= 1'b1;
        nd  <= 16'h1235;
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        repeat (10) @(posedge CLK);
        chk("bim_battery", 0, bme);
        bat <= 1'b0;
        repeat (8) @(posedge CLK);
        chk("bim_mismatch", 1, bme);
        print_verdict();
    end
endmodule : test_tazi_core
